/* File: rtl/cpd_defines.svh */
`ifndef CPD_DEFINES_SVH
`define CPD_DEFINES_SVH

// Register offsets; printed offsets are not multiples of four, so they are indices.
`define CPD_IDX_OPTIONS 8'h3A
`define CPD_IDX_Q_LOWER 8'h3F
`define CPD_IDX_Q_UPPER 8'h40
`define CPD_IDX_I_LOWER 8'h41
`define CPD_IDX_I_RESULT 8'h42
`define CPD_IDX_Q_RESULT 8'h43
`define CPD_IDX_IRQ_STATUS 8'h50
`define CPD_IDX_IRQ_MASK 8'h51

// Field positions.
`define CPD_OPT_TX_FULL_BIT 3
`define CPD_OPT_FILTER_BIT 2
`define CPD_OPT_Q_UNSTABLE_BIT 1
`define CPD_OPT_I_UNSTABLE_BIT 0
`define CPD_Q_RESULT_SUPPRESS_BIT 6

// Reset values.
`define CPD_RST_BYTE 8'h00

// Timing: longest sampling time with the filter on, in nanoseconds.
`define CPD_FILTER_MAX_SAMPLE_NS 4720
`define CPD_CLK_PERIOD_NS 4
`define CPD_FILTER_MAX_SAMPLE_CYC (`CPD_FILTER_MAX_SAMPLE_NS / `CPD_CLK_PERIOD_NS)

`endif

/* File: rtl/cpd_pkg.sv */
package cpd_pkg;
  typedef enum logic [1:0] {
    CPD_IDLE = 2'b00,
    CPD_MEASURE = 2'b01,
    CPD_DONE = 2'b10
  } cpd_state_e;
endpackage

/* File: rtl/cpd_card_presence_detect.sv */
// Functional notes
// RULE_01 - I upper border bits 3:2 from Q upper reg 7:6, bits 1:0 from I lower 7:6.
// RULE_02 - Interrupt when Q value exceeds Q upper border in bits 5:0.
// RULE_03 - Interrupt when I value exceeds the assembled I upper border.
// RULE_04 - Interrupt when I value is below I lower border in bits 5:0.
// RULE_05 - I result register shows last I value in bits 5:0; 7:6 reserved.
// RULE_06 - Q result register shows last Q value in bits 5:0; bit 7 reserved.
// RULE_07 - Suppress bit 6 blocks further detection interrupts until the next run starts.
// RULE_08 - Option bit 3 selects full transmitter supply, else supply minus 0.4V.
// RULE_09 - Option bit 2 bases decision on filtered values; sampling at most 4.72us.
// RULE_10 - With filter on, option bit 1 flags Q converter value changed.
// RULE_11 - With filter on, option bit 0 flags I converter value changed.
// RULE_12 - Options register exists only on later version; bits 7:4 reserved.
// RULE_13 - I upper border bits 5:4 from Q lower reg 7:6; 5:0 hold Q lower.
// RULE_14 - Every raised detection interrupt sets the detection flag in status.
// RULE_15 - Reserved bits read zero and ignore writes.
//
// The implementer's own choice: register access over APB.
`include "cpd_defines.svh"

module cpd_card_presence_detect #(
  parameter bit HAS_OPTIONS = 1'b1,
  parameter int SAMPLE_CYC = `CPD_FILTER_MAX_SAMPLE_CYC
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Measurement front end.
  input wire logic i_run_start,
  input wire logic i_sample_valid,
  input wire logic [5:0] i_i_sample,
  input wire logic [5:0] i_q_sample,
  // Analogue controls.
  output logic o_full_supply_tx_drive,
  output logic o_noise_filter_enable,
  output logic o_measuring,
  // Interrupt.
  output logic o_irq
);

  // Software visible configuration and results.
  logic [7:0] q_lower_border_reg;
  logic [7:0] q_upper_border_reg;
  logic [7:0] i_lower_border_reg;
  logic [5:0] i_last_result;
  logic [5:0] q_last_result;
  logic detect_irq_suppress;
  logic full_supply_tx_drive;
  logic noise_filter_enable;
  logic q_unstable_flag;
  logic i_unstable_flag;
  logic detect_irq_flag;
  logic irq_mask;
  // Run sequencing and filter state.
  cpd_pkg::cpd_state_e state;
  logic [31:0] sample_cnt;
  logic [5:0] i_first;
  logic [5:0] q_first;
  logic first_seen;
  logic [6:0] i_acc;
  logic [6:0] q_acc;
  logic [5:0] i_eval;
  logic [5:0] q_eval;
  logic [5:0] i_upper_border;
  // Border evaluation and bus decode.
  logic detect_hit;
  logic wr_en;
  logic rd_en;
  logic [7:0] idx;
  logic idx_hit;
  logic w_clear_irq;
  logic sample_take;
  logic run_end;
  logic filter_limit;
  logic [7:0] next_rdata;

  // Registers sit one per word, so the register index is the word address.
  assign idx = i_paddr[9:2];
  // A write lands only in the access cycle that the slave completes.
  assign wr_en = i_psel && i_penable && i_pwrite && o_pready;
  // Read data is fetched in the setup cycle so it is ready together with pready.
  assign rd_en = i_psel && !i_penable && !i_pwrite;
  // The I upper border has no register of its own; its six bits are spread over
  // the top two bits of three other registers, most significant part first.
  assign i_upper_border = {q_lower_border_reg[7:6], q_upper_border_reg[7:6], i_lower_border_reg[7:6]}; // RULE_01 RULE_13
  assign sample_take = (state == cpd_pkg::CPD_MEASURE) && i_sample_valid;
  // With the filter off the first sample decides; with it on the run is cut at
  // the sampling limit, which bounds how long the transmitter stays on.
  assign filter_limit = (sample_cnt >= SAMPLE_CYC - 1);
  assign run_end = (state == cpd_pkg::CPD_MEASURE) &&
    ((sample_take && !noise_filter_enable) || filter_limit); // RULE_09
  // Only bit 0 of the status word can be cleared; the other bits are reserved.
  // A clear that misses the word alignment is dropped like any other misaligned write.
  assign w_clear_irq = wr_en && (idx == `CPD_IDX_IRQ_STATUS) && (i_paddr[1:0] == 2'b00) && i_pwdata[0];

  // With the filter on, the decision uses a two-sample average to smooth noise.
  // The first sample of a run has nothing to average with, so it is judged raw.
  // The average lags one sample behind, which trades reaction time for stability.
  always_comb begin
    if (noise_filter_enable && first_seen) begin // RULE_09
      i_eval = i_acc[6:1];
      q_eval = q_acc[6:1];
    end else begin
      i_eval = i_i_sample;
      q_eval = i_q_sample;
    end
  end

  // Any one border crossing is enough to call a card; the checks are independent.
  // Equal values are inside the window on both borders.
  // There is no Q lower border check here; that border is only stored.
  always_comb begin
    detect_hit = 1'b0;
    if (q_eval > q_upper_border_reg[5:0]) begin // RULE_02
      detect_hit = 1'b1;
    end
    if (i_eval > i_upper_border) begin // RULE_03
      detect_hit = 1'b1;
    end
    if (i_eval < i_lower_border_reg[5:0]) begin // RULE_04
      detect_hit = 1'b1;
    end
  end

  // Detection run sequencing.
  // A run is only accepted from idle, so a stray start pulse mid-run is ignored.
  // The done state gives the result registers one quiet cycle before the next run.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= cpd_pkg::CPD_IDLE;
      sample_cnt <= 32'h0000_0000;
    end else begin
      unique case (state)
        cpd_pkg::CPD_IDLE: begin
          // The counter is held at zero so each run measures from a clean start.
          sample_cnt <= 32'h0000_0000;
          if (i_run_start) begin
            state <= cpd_pkg::CPD_MEASURE;
          end
        end
        cpd_pkg::CPD_MEASURE: begin
          sample_cnt <= sample_cnt + 32'h0000_0001;
          // The filtered run is cut at the sampling limit to bound RF-on time.
          if (run_end) begin // RULE_09
            state <= cpd_pkg::CPD_DONE;
          end
        end
        cpd_pkg::CPD_DONE: begin
          // A start seen here is lost; the front end only starts runs while idle.
          state <= cpd_pkg::CPD_IDLE;
        end
        default: begin
          // The unused state code recovers to idle.
          state <= cpd_pkg::CPD_IDLE;
        end
      endcase
    end
  end

  // Results and the reference sample of each run.
  // With the filter on, a later sample that differs from the reference marks its channel unstable.
  // The flags are cleared when a run starts, so they describe one run only.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      i_last_result <= 6'h00;
      q_last_result <= 6'h00;
      i_first <= 6'h00;
      q_first <= 6'h00;
      first_seen <= 1'b0;
      i_acc <= 7'h00;
      q_acc <= 7'h00;
    end else begin
      if (state == cpd_pkg::CPD_IDLE && i_run_start) begin
        first_seen <= 1'b0;
      end else if (sample_take) begin
        i_last_result <= i_eval; // RULE_05
        q_last_result <= q_eval; // RULE_06
        first_seen <= 1'b1;
        // The sum keeps one spare bit so the average of two six-bit values cannot wrap.
        i_acc <= {1'b0, i_i_sample} + {1'b0, first_seen ? i_first : i_i_sample};
        q_acc <= {1'b0, i_q_sample} + {1'b0, first_seen ? q_first : i_q_sample};
        // The first sample of a run is the reference for the unstable flags.
        if (!first_seen) begin
          i_first <= i_i_sample;
          q_first <= i_q_sample;
        end
      end
    end
  end

  // Per channel instability tracking: channel 0 is I, channel 1 is Q.
  // Changes are only recorded with the filter on, where the flags have meaning.
  logic [1:0][5:0] chan_sample;
  logic [1:0][5:0] chan_first;
  wire [1:0] chan_unstable;
  assign chan_sample = {i_q_sample, i_i_sample};
  assign chan_first = {q_first, i_first};
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_unstable
      logic unstable;
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          unstable <= 1'b0;
        end else if (state == cpd_pkg::CPD_IDLE && i_run_start) begin
          unstable <= 1'b0;
        end else if (sample_take && first_seen && noise_filter_enable) begin
          if (chan_sample[ch] != chan_first[ch]) begin
            unstable <= 1'b1;
          end
        end
      end
      assign chan_unstable[ch] = unstable;
    end
  endgenerate
  assign i_unstable_flag = chan_unstable[0]; // RULE_11
  assign q_unstable_flag = chan_unstable[1]; // RULE_10

  // Software writable configuration.
  // Misaligned writes are dropped so a byte lane mistake cannot change a border.
  // On the earlier silicon the options word is inert and reads back as zero.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q_lower_border_reg <= `CPD_RST_BYTE;
      q_upper_border_reg <= `CPD_RST_BYTE;
      i_lower_border_reg <= `CPD_RST_BYTE;
      full_supply_tx_drive <= 1'b0;
      noise_filter_enable <= 1'b0;
      irq_mask <= 1'b0;
    end else if (wr_en && i_paddr[1:0] == 2'b00) begin
      unique case (idx)
        `CPD_IDX_Q_LOWER: q_lower_border_reg <= i_pwdata[7:0];
        `CPD_IDX_Q_UPPER: q_upper_border_reg <= i_pwdata[7:0];
        `CPD_IDX_I_LOWER: i_lower_border_reg <= i_pwdata[7:0];
        `CPD_IDX_OPTIONS: begin
          if (HAS_OPTIONS) begin // RULE_12
            full_supply_tx_drive <= i_pwdata[`CPD_OPT_TX_FULL_BIT]; // RULE_08
            noise_filter_enable <= i_pwdata[`CPD_OPT_FILTER_BIT]; // RULE_09
          end
        end
        // The mask only gates the pin; the status flag is set regardless.
        `CPD_IDX_IRQ_MASK: irq_mask <= i_pwdata[0];
        default: begin
        end
      endcase
    end
  end

  // Suppress holds off detection interrupts until a new run starts.
  // Software sets it after reading a hit to stop the flag from being set again.
  // A start wins over a write in the same cycle, so that write cannot mute the new run.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      detect_irq_suppress <= 1'b0;
    end else if (state == cpd_pkg::CPD_IDLE && i_run_start) begin
      detect_irq_suppress <= 1'b0; // RULE_07
    end else if (wr_en && idx == `CPD_IDX_Q_RESULT && i_paddr[1:0] == 2'b00) begin
      detect_irq_suppress <= i_pwdata[`CPD_Q_RESULT_SUPPRESS_BIT]; // RULE_07
    end
  end

  // Sticky detection flag; a new hit wins over a write-one clear in the same cycle.
  // Only a sample that is actually taken can raise the flag.
  // Losing the hit instead would hide a card that arrived during the clear.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      detect_irq_flag <= 1'b0;
    end else if (sample_take && detect_hit && !detect_irq_suppress) begin
      detect_irq_flag <= 1'b1; // RULE_14 RULE_07
    end else if (w_clear_irq) begin
      detect_irq_flag <= 1'b0;
    end
  end

  // Read data for the addressed register; reserved bits are tied to zero.
  // Unmapped, misaligned or out of range addresses are flagged for pslverr.
  // The decode is shared by reads and by the error response of writes.
  always_comb begin
    next_rdata = 8'h00;
    idx_hit = 1'b1;
    unique case (idx)
      `CPD_IDX_Q_LOWER: next_rdata = q_lower_border_reg;
      `CPD_IDX_Q_UPPER: next_rdata = q_upper_border_reg;
      `CPD_IDX_I_LOWER: next_rdata = i_lower_border_reg;
      `CPD_IDX_I_RESULT: next_rdata = {2'b00, i_last_result}; // RULE_05 RULE_15
      `CPD_IDX_Q_RESULT: next_rdata = {1'b0, detect_irq_suppress, q_last_result}; // RULE_06 RULE_15
      `CPD_IDX_OPTIONS: begin
        if (HAS_OPTIONS) begin
          next_rdata = {4'h0, full_supply_tx_drive, noise_filter_enable,
            q_unstable_flag && noise_filter_enable, i_unstable_flag && noise_filter_enable}; // RULE_12 RULE_15
        end
      end
      `CPD_IDX_IRQ_STATUS: next_rdata = {7'h00, detect_irq_flag};
      `CPD_IDX_IRQ_MASK: next_rdata = {7'h00, irq_mask};
      default: idx_hit = 1'b0;
    endcase
    if (i_paddr[1:0] != 2'b00 || i_paddr[11:10] != 2'b00) begin
      idx_hit = 1'b0;
    end
  end

  // APB answers in the first access cycle; unmapped addresses return an error.
  // Pready is a one-cycle pulse, so the slave never inserts wait states.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !idx_hit;
      // Read data is reloaded on every setup so a write or a refused read shows zero.
      if (i_psel && !i_penable) begin
        if (rd_en && idx_hit) begin
          o_prdata <= {24'h00_0000, next_rdata};
        end else begin
          o_prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // Every output is registered, so the pins lag the internal state by one cycle.
  // The interrupt line is the masked detection flag.
  // The measuring output lets the analogue side power up only during a run.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_full_supply_tx_drive <= 1'b0;
      o_noise_filter_enable <= 1'b0;
      o_measuring <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_full_supply_tx_drive <= full_supply_tx_drive; // RULE_08
      o_noise_filter_enable <= noise_filter_enable;
      o_measuring <= (state == cpd_pkg::CPD_MEASURE);
      o_irq <= detect_irq_flag && irq_mask;
    end
  end

endmodule

/* File: dv/cpd_checker.sv */
`include "cpd_defines.svh"

module cpd_checker #(
  parameter int SAMPLE_CYC = 8
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // APB slave.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // Measurement front end and controls.
  input wire logic i_run_start,
  input wire logic i_sample_valid,
  input wire logic [5:0] i_i_sample,
  input wire logic [5:0] i_q_sample,
  input wire logic o_full_supply_tx_drive,
  input wire logic o_noise_filter_enable,
  input wire logic o_measuring,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic [1:0] opt_q;
  int meas_cnt;
  wire opt_wr = i_psel && i_penable && o_pready && i_pwrite && i_paddr[9:2] == `CPD_IDX_OPTIONS;
  // The last options write is kept so the drive outputs can be compared two cycles later.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      opt_q <= 2'b00;
      meas_cnt <= 0;
    end else begin
      if (opt_wr) opt_q <= i_pwdata[3:2];
      meas_cnt <= o_measuring ? meas_cnt + 1 : 0;
    end
  end
  pready_time_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready missing after setup");
  pready_phase_a: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access phase");
  slverr_pair_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  rdata_zero_a: assert property (o_pready |-> o_prdata[31:8] == 24'h0 && (!o_pslverr || o_prdata == 32'h0))
    else $error("read data upper bits not zero");
  tx_drive_a: assert property (opt_wr |=> ##1 o_full_supply_tx_drive == opt_q[1])
    else $error("drive level does not follow options");
  filter_out_a: assert property (opt_wr |=> ##1 o_noise_filter_enable == opt_q[0])
    else $error("filter enable does not follow options");
  run_cause_a: assert property ($rose(o_measuring) |-> $past(i_run_start, 2))
    else $error("run began without start");
  single_sample_a: assert property (o_measuring && !o_noise_filter_enable && i_sample_valid |=> ##[0:1] !o_measuring)
    else $error("unfiltered run did not end");
  sample_time_a: assert property (o_noise_filter_enable |-> meas_cnt <= SAMPLE_CYC + 2)
    else $error("filtered run too long");
  cover property (o_irq);
  cover property (opt_wr);
  cover property (o_pslverr);
endmodule

bind cpd_card_presence_detect cpd_checker #(.SAMPLE_CYC(SAMPLE_CYC)) chk_u (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_run_start(i_run_start),
  .i_sample_valid(i_sample_valid), .i_i_sample(i_i_sample), .i_q_sample(i_q_sample),
  .o_full_supply_tx_drive(o_full_supply_tx_drive), .o_noise_filter_enable(o_noise_filter_enable),
  .o_measuring(o_measuring), .o_irq(o_irq));

/* File: dv/tb_top.sv */
`include "cpd_defines.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_nrst = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_run_start = 0, i_sample_valid = 0;
  logic [11:0] i_paddr = '0;
  logic [31:0] i_pwdata = '0, o_prdata;
  logic [5:0] i_i_sample = '0, i_q_sample = '0;
  logic o_pready, o_pslverr, o_full_supply_tx_drive, o_noise_filter_enable, o_measuring, o_irq, err;
  logic [15:0] seed = 16'h6AF9;
  logic [31:0] rd;
  int n_fail = 0, n_tests = 0;
  cpd_card_presence_detect #(.SAMPLE_CYC(8)) dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_run_start(i_run_start), .i_sample_valid(i_sample_valid),
    .i_i_sample(i_i_sample), .i_q_sample(i_q_sample), .o_full_supply_tx_drive(o_full_supply_tx_drive),
    .o_noise_filter_enable(o_noise_filter_enable), .o_measuring(o_measuring), .o_irq(o_irq));
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  function automatic logic [7:0] nx();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  function automatic logic [7:0] expf(input logic [7:0] ql, qu, il, input logic [5:0] si, sq);
    logic [5:0] imax;
    imax = {ql[7:6], qu[7:6], il[7:6]};
    return {7'h0, (si > imax) || (sq > qu[5:0]) || (si < il[5:0])};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Pready, read data and error are taken at the rising edge that completes the access.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int k;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= {2'b00, idx, 2'b00};
    i_pwdata <= {24'h0, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    k = 0;
    @(posedge i_clk);
    while (o_pready !== 1'b1 && k < 20) begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 20) n_fail++;
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(rd[7:0], e);
  endtask
  task automatic irqc(input logic e);
    @(negedge i_clk);
    chk({7'h0, o_irq}, {7'h0, e});
    @(posedge i_clk);
  endtask
  task automatic start();
    i_run_start <= 1'b1;
    @(posedge i_clk);
    i_run_start <= 1'b0;
  endtask
  task automatic samp(input logic [5:0] si, input logic [5:0] sq, input logic w);
    int k;
    i_i_sample <= si;
    i_q_sample <= sq;
    i_sample_valid <= 1'b1;
    @(posedge i_clk);
    i_sample_valid <= 1'b0;
    @(posedge i_clk);
    k = 0;
    while (w && o_measuring !== 1'b0 && k < 40) begin
      @(negedge i_clk);
      k++;
    end
    if (w) @(posedge i_clk);
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
  initial begin
    logic [7:0] ql, qu, il;
    logic [5:0] si, sq;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    apb(1'b0, 8'h7F, 8'h00);
    chk({7'h0, err}, 8'h01);
    apb(1'b1, `CPD_IDX_OPTIONS, 8'hFF);
    rdc(`CPD_IDX_OPTIONS, 8'h0C);
    chk({6'h0, o_full_supply_tx_drive, o_noise_filter_enable}, 8'h03);
    apb(1'b1, `CPD_IDX_Q_LOWER, 8'hC0);
    apb(1'b1, `CPD_IDX_Q_UPPER, 8'hD4);
    apb(1'b1, `CPD_IDX_I_LOWER, 8'hCA);
    start();
    samp(6'h0A, 6'h12, 1'b0);
    samp(6'h0C, 6'h12, 1'b1);
    rdc(`CPD_IDX_OPTIONS, 8'h0D);
    start();
    samp(6'h0A, 6'h12, 1'b0);
    samp(6'h0A, 6'h13, 1'b1);
    rdc(`CPD_IDX_OPTIONS, 8'h0E);
    apb(1'b1, `CPD_IDX_OPTIONS, 8'h00);
    rdc(`CPD_IDX_OPTIONS, 8'h00);
    apb(1'b1, `CPD_IDX_IRQ_STATUS, 8'h01);
    apb(1'b1, `CPD_IDX_IRQ_MASK, 8'h00);
    start();
    samp(6'h09, 6'h14, 1'b1);
    rdc(`CPD_IDX_IRQ_STATUS, 8'h01);
    irqc(1'b0);
    apb(1'b1, `CPD_IDX_IRQ_MASK, 8'h01);
    irqc(1'b1);
    apb(1'b1, `CPD_IDX_IRQ_STATUS, 8'h01);
    start();
    apb(1'b1, `CPD_IDX_Q_RESULT, 8'h40);
    samp(6'h09, 6'h14, 1'b1);
    rdc(`CPD_IDX_IRQ_STATUS, 8'h00);
    for (int n = 0; n < 14; n++) begin
      ql = {nx() & 8'hC0};
      qu = nx();
      il = nx();
      si = 6'(nx());
      sq = 6'(nx());
      if (n < 2) begin
        ql = 8'hC0;
        qu = 8'hD4;
        il = 8'hCA;
        si = 6'h0A - 6'(n);
        sq = 6'h14;
      end
      apb(1'b1, `CPD_IDX_Q_LOWER, ql);
      apb(1'b1, `CPD_IDX_Q_UPPER, qu);
      apb(1'b1, `CPD_IDX_I_LOWER, il);
      rdc(`CPD_IDX_Q_UPPER, qu);
      rdc(`CPD_IDX_I_LOWER, il);
      start();
      samp(si, sq, 1'b1);
      rdc(`CPD_IDX_I_RESULT, {2'b00, si});
      rdc(`CPD_IDX_Q_RESULT, {2'b00, sq});
      rdc(`CPD_IDX_IRQ_STATUS, expf(ql, qu, il, si, sq));
      irqc(expf(ql, qu, il, si, sq) == 8'h01);
      apb(1'b1, `CPD_IDX_IRQ_STATUS, 8'h01);
      irqc(1'b0);
    end
    summarize();
  end
endmodule
